// ===== rtl/ceb_pkg.sv
package ceb_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned E_PERIOD_NS   = 1000;
   localparam int unsigned E_DIV         = E_PERIOD_NS / 20;
   localparam int unsigned E_HALF        = E_DIV / 2;

   localparam logic [1:0] ST_RUN      = 2'h0;
   localparam logic [1:0] ST_INT_ACK  = 2'h1;
   localparam logic [1:0] ST_SYNC_ACK = 2'h2;
   localparam logic [1:0] ST_HALT     = 2'h3;

   typedef struct packed {
      logic       enable_clk;
      logic       ungated_sync_clk;
      logic       valid_mem_cycle;
      logic       rd_wr;
      logic       user_map_qualifier;
      logic       exec_map_qualifier;
      logic [1:0] cpu_state_code;
   } ceb_bus_out_t;

   typedef enum logic [1:0] {
      CEB_RUN,
      CEB_IRQ_SEQ,
      CEB_NMI_SEQ,
      CEB_HALTED
   } ceb_state_t;
endpackage

// ===== rtl/ceb_bus_ctrl.sv
`timescale 1ns/1ns
module ceb_bus_ctrl #(
   parameter int unsigned E_DIV = ceb_pkg::E_DIV
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               irq_n_i,
   input  wire logic               nmi_n_i,
   input  wire logic               insn_done_i,
   input  wire logic               irq_mask_i,
   input  wire logic               halt_req_i,
   input  wire logic               sync_ack_i,
   input  wire logic               cpu_write_i,
   input  wire logic               user_map_sel_i,
   input  wire logic               ack_done_i,
   output ceb_pkg::ceb_bus_out_t   bus_o,
   output logic                    irq_take_o,
   output logic                    nmi_take_o
);

   // The divider counter is eight bits wide, and each clock phase must last two cycles or more.
   if (E_DIV < 4 || E_DIV % 2 != 0 || E_DIV > 512) begin : g_bad_div
      $error("E_DIV must be even and between 4 and 512");
   end

   typedef struct packed {
      logic [7:0]            div_cnt;
      logic                  e_clk;
      logic                  nmi_n_last;
      logic                  nmi_pend;
      ceb_pkg::ceb_state_t   st;
      ceb_pkg::ceb_bus_out_t bus;
      logic                  irq_take;
      logic                  nmi_take;
   } ceb_regs_t;

   ceb_regs_t s_reg;
   ceb_regs_t s_next;

   localparam logic [7:0] HALF = 8'(E_DIV / 2 - 1);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next          = s_reg;
      s_next.irq_take = 1'b0;
      s_next.nmi_take = 1'b0;
      if (s_reg.div_cnt == HALF) begin
         s_next.div_cnt = 8'h00;
         s_next.e_clk   = ~s_reg.e_clk;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 8'h01;
      end
      // falling edge capture; a new edge wins over the clear when taken.
      s_next.nmi_n_last = nmi_n_i;
      unique case (s_reg.st)
         ceb_pkg::CEB_RUN: begin
            if (halt_req_i) begin
               s_next.st = ceb_pkg::CEB_HALTED;
            end else if (insn_done_i && s_reg.nmi_pend) begin
               s_next.st       = ceb_pkg::CEB_NMI_SEQ;
               s_next.nmi_pend = 1'b0;
               s_next.nmi_take = 1'b1;
            end else if (insn_done_i && !irq_n_i && !irq_mask_i) begin
               s_next.st       = ceb_pkg::CEB_IRQ_SEQ;
               s_next.irq_take = 1'b1;
            end
         end
         ceb_pkg::CEB_IRQ_SEQ, ceb_pkg::CEB_NMI_SEQ: begin
            if (ack_done_i) s_next.st = ceb_pkg::CEB_RUN;
         end
         ceb_pkg::CEB_HALTED: begin
            if (!halt_req_i) s_next.st = ceb_pkg::CEB_RUN;
         end
      endcase
      if (s_reg.nmi_n_last && !nmi_n_i) s_next.nmi_pend = 1'b1;
      s_next.bus.enable_clk       = s_next.e_clk;
      s_next.bus.ungated_sync_clk = s_next.e_clk;
      s_next.bus.valid_mem_cycle  = 1'b1;
      s_next.bus.rd_wr = !(cpu_write_i && s_next.st != ceb_pkg::CEB_HALTED);
      s_next.bus.user_map_qualifier = user_map_sel_i;
      s_next.bus.exec_map_qualifier = ~user_map_sel_i;
      unique case (s_next.st)
         ceb_pkg::CEB_RUN:     s_next.bus.cpu_state_code = sync_ack_i ? ceb_pkg::ST_SYNC_ACK
                                                                      : ceb_pkg::ST_RUN;
         ceb_pkg::CEB_HALTED:  s_next.bus.cpu_state_code = ceb_pkg::ST_HALT;
         default:              s_next.bus.cpu_state_code = ceb_pkg::ST_INT_ACK;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg     <= '0;
         s_reg.nmi_n_last <= 1'b1;
         s_reg.bus.rd_wr  <= 1'b1;
         s_reg.bus.valid_mem_cycle <= 1'b1;
         s_reg.bus.exec_map_qualifier <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // unused lines are not ports of this block.
   assign bus_o      = s_reg.bus;
   assign irq_take_o = s_reg.irq_take;
   assign nmi_take_o = s_reg.nmi_take;

   ////////////////////////////////////////////////////////////////////////////
   property p_vma;
      @(posedge clk_i) disable iff (!rst_n_i) bus_o.valid_mem_cycle;
   endproperty
   a_vma: assert property (p_vma) else $error("valid cycle line low");

   property p_mirror;
      @(posedge clk_i) disable iff (!rst_n_i) bus_o.ungated_sync_clk == bus_o.enable_clk;
   endproperty
   a_mirror: assert property (p_mirror) else $error("memory clock differs");

   property p_eclk;
      @(posedge clk_i) disable iff (!rst_n_i)
         $rose(bus_o.enable_clk) |-> bus_o.enable_clk [*2];
   endproperty
   a_eclk: assert property (p_eclk) else $error("enable clock high too short");

   property p_irq_mask;
      @(posedge clk_i) disable iff (!rst_n_i)
         irq_take_o |-> $past(insn_done_i) && !$past(irq_mask_i) && !$past(irq_n_i);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq taken");

   property p_irq_level;
      @(posedge clk_i) disable iff (!rst_n_i)
         irq_take_o |-> bus_o.cpu_state_code == ceb_pkg::ST_INT_ACK;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq ack code wrong");

   sequence s_nmi_fall;
      $fell(nmi_n_i) && s_reg.st == ceb_pkg::CEB_RUN && !halt_req_i;
   endsequence
   property p_nmi;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_nmi_fall ##1 (insn_done_i && !halt_req_i && s_reg.st == ceb_pkg::CEB_RUN)
         |=> nmi_take_o;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not taken");

   property p_halt_code;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_reg.st == ceb_pkg::CEB_HALTED |-> bus_o.cpu_state_code == ceb_pkg::ST_HALT;
   endproperty
   a_halt_code: assert property (p_halt_code) else $error("halt code wrong");

   property p_halt_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_reg.st == ceb_pkg::CEB_HALTED |-> bus_o.rd_wr;
   endproperty
   a_halt_read: assert property (p_halt_read) else $error("write while halted");

   property p_map;
      @(posedge clk_i) disable iff (!rst_n_i)
         bus_o.user_map_qualifier != bus_o.exec_map_qualifier;
   endproperty
   a_map: assert property (p_map) else $error("map qualifiers clash");

   property p_map_follow;
      @(posedge clk_i) disable iff (!rst_n_i)
         bus_o.user_map_qualifier == $past(user_map_sel_i);
   endproperty
   a_map_follow: assert property (p_map_follow) else $error("user map not followed");

   property p_eclk_low;
      @(posedge clk_i) disable iff (!rst_n_i)
         $fell(bus_o.enable_clk) |-> !bus_o.enable_clk [*2];
   endproperty
   a_eclk_low: assert property (p_eclk_low) else $error("enable clock low too short");

   property p_nmi_code;
      @(posedge clk_i) disable iff (!rst_n_i)
         nmi_take_o |-> bus_o.cpu_state_code == ceb_pkg::ST_INT_ACK;
   endproperty
   a_nmi_code: assert property (p_nmi_code) else $error("nmi ack code wrong");

   property p_nmi_prio;
      @(posedge clk_i) disable iff (!rst_n_i)
         irq_take_o |-> !$past(s_reg.nmi_pend);
   endproperty
   a_nmi_prio: assert property (p_nmi_prio) else $error("irq taken over pending nmi");

   property p_ack_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         irq_take_o && !ack_done_i |=> bus_o.cpu_state_code == ceb_pkg::ST_INT_ACK;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack code dropped early");

   property p_write_run;
      @(posedge clk_i) disable iff (!rst_n_i)
         $past(cpu_write_i) && s_reg.st == ceb_pkg::CEB_RUN |-> !bus_o.rd_wr;
   endproperty
   a_write_run: assert property (p_write_run) else $error("write not shown");

   property p_idle_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         !$past(cpu_write_i) |-> bus_o.rd_wr;
   endproperty
   a_idle_read: assert property (p_idle_read) else $error("idle line not read");

   property p_sync_code;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_reg.st == ceb_pkg::CEB_RUN && $past(sync_ack_i)
         |-> bus_o.cpu_state_code == ceb_pkg::ST_SYNC_ACK;
   endproperty
   a_sync_code: assert property (p_sync_code) else $error("sync code wrong");

   property p_run_code;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_reg.st == ceb_pkg::CEB_RUN && !$past(sync_ack_i)
         |-> bus_o.cpu_state_code == ceb_pkg::ST_RUN;
   endproperty
   a_run_code: assert property (p_run_code) else $error("run code wrong");

   property p_halt_enter;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_reg.st == ceb_pkg::CEB_RUN && halt_req_i |=> s_reg.st == ceb_pkg::CEB_HALTED;
   endproperty
   a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");

endmodule // ceb_bus_ctrl

// ===== verification/ceb_plugin_model.sv
`timescale 1ns/1ns
module ceb_plugin_model (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic req_irq_i,
   input  wire logic req_nmi_i,
   input  wire logic enable_clk_i,
   input  wire logic map2_i,
   input  wire logic rd_wr_i,
   output logic      data_oe_o,
   output logic      irq_n_o,
   output logic      nmi_n_o
);
   logic nmi_d_reg;
   // no map jumpers, so the model answers in map 2 only.
   // data is driven only while selected, reading and enable clock high.
   assign data_oe_o = map2_i & enable_clk_i & rd_wr_i;
   assign irq_n_o = ~req_irq_i;
   // edge request
   // The low pulse lasts one cycle, so only the falling edge can start a sequence.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nmi_d_reg <= 1'b0;
         nmi_n_o   <= 1'b1;
      end else begin
         nmi_d_reg <= req_nmi_i;
         nmi_n_o   <= ~(req_nmi_i & ~nmi_d_reg);
      end
   end
endmodule // ceb_plugin_model

// ===== verification/cpu_expansion_bus_signals_bench.sv
`timescale 1ns/1ns
module cpu_expansion_bus_signals_bench;
   logic clk_i = 1'b0, rst_n_i = 1'b0, insn_done_i = 1'b0, irq_mask_i = 1'b0;
   logic halt_req_i = 1'b0, sync_ack_i = 1'b0, cpu_write_i = 1'b0, user_map_sel_i = 1'b0;
   logic ack_done_i = 1'b0, req_irq = 1'b0, req_nmi = 1'b0, irq_n, nmi_n, ti, tn;
   logic irq_take_o, nmi_take_o, data_oe;
   ceb_pkg::ceb_bus_out_t bus_o;
   int fails = 0, n_tests = 0, edges;
   always #10 clk_i = ~clk_i;
   ceb_bus_ctrl #(.E_DIV(4)) i_ceb_bus_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .irq_n_i(irq_n), .nmi_n_i(nmi_n), .insn_done_i(insn_done_i), .irq_mask_i(irq_mask_i),
      .halt_req_i(halt_req_i), .sync_ack_i(sync_ack_i), .cpu_write_i(cpu_write_i),
      .user_map_sel_i(user_map_sel_i), .ack_done_i(ack_done_i), .bus_o(bus_o),
      .irq_take_o(irq_take_o), .nmi_take_o(nmi_take_o));
   ceb_plugin_model i_ceb_plugin_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .req_irq_i(req_irq), .req_nmi_i(req_nmi), .enable_clk_i(bus_o.enable_clk),
      .map2_i(bus_o.exec_map_qualifier), .rd_wr_i(bus_o.rd_wr), .data_oe_o(data_oe),
      .irq_n_o(irq_n), .nmi_n_o(nmi_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic run_insn();
      ti = 1'b0;
      tn = 1'b0;
      @(posedge clk_i) insn_done_i <= 1'b1;
      @(posedge clk_i) insn_done_i <= 1'b0;
      repeat (3) begin
         #1 ti = ti | irq_take_o;
         tn = tn | nmi_take_o;
         @(posedge clk_i);
      end
   endtask
   task automatic ack();
      @(posedge clk_i) ack_done_i <= 1'b1;
      @(posedge clk_i) ack_done_i <= 1'b0;
      cyc(2);
      chk("code after ack", ceb_pkg::ST_RUN, bus_o.cpu_state_code);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      rst_n_i <= 1'b1;
      cyc(1);
      chk("valid", 8'h1, bus_o.valid_mem_cycle);
      chk("rd_wr idle", 8'h1, bus_o.rd_wr);
      chk("code", ceb_pkg::ST_RUN, bus_o.cpu_state_code);
      irq_mask_i <= 1'b1;
      req_irq <= 1'b1;
      run_insn();
      chk("masked irq", 8'h0, ti);
      irq_mask_i <= 1'b0;
      run_insn();
      chk("irq take", 8'h1, ti);
      chk("int ack", ceb_pkg::ST_INT_ACK, bus_o.cpu_state_code);
      req_irq <= 1'b0;
      ack();
      irq_mask_i <= 1'b1;
      req_nmi <= 1'b1;
      cyc(3);
      run_insn();
      chk("nmi take", 8'h1, tn);
      chk("nmi ack", ceb_pkg::ST_INT_ACK, bus_o.cpu_state_code);
      req_nmi <= 1'b0;
      ack();
      halt_req_i <= 1'b1;
      cpu_write_i <= 1'b1;
      cyc(3);
      chk("halt code", ceb_pkg::ST_HALT, bus_o.cpu_state_code);
      chk("rd_wr halt", 8'h1, bus_o.rd_wr);
      halt_req_i <= 1'b0;
      sync_ack_i <= 1'b1;
      cyc(3);
      chk("sync code", ceb_pkg::ST_SYNC_ACK, bus_o.cpu_state_code);
      chk("rd_wr write", 8'h0, bus_o.rd_wr);
      sync_ack_i <= 1'b0;
      cpu_write_i <= 1'b0;
      cyc(3);
      edges = 0;
      repeat (16) begin
         ti = bus_o.enable_clk;
         cyc(1);
         edges += int'(ti !== bus_o.enable_clk);
         chk("mem clk copy", bus_o.enable_clk, bus_o.ungated_sync_clk);
         chk("data window", 8'(bus_o.enable_clk), data_oe);
      end
      chk("enable edges", 8'd8, edges[7:0]);
      user_map_sel_i <= 1'b1;
      cyc(2);
      chk("user map", 8'h2, {bus_o.user_map_qualifier, bus_o.exec_map_qualifier});
      user_map_sel_i <= 1'b0;
      cyc(2);
      chk("exec map", 8'h1, {bus_o.user_map_qualifier, bus_o.exec_map_qualifier});
      end_sim();
   end
endmodule // cpu_expansion_bus_signals_bench
